//--- hdl/emc_pkg.sv
// How it works
// RULE_01 - Transmit settings: duplex, auto FCS, padding
// RULE_02 - Receive settings: bad FCS, multicast, promiscuous
// RULE_03 - Timestamp enable routes tx/rx status to capture
// RULE_04 - Bad-FCS reject discards frames with wrong FCS
// RULE_05 - Disable stops tx/rx, flushes receive FIFO
// RULE_06 - Enable starts tx/rx, receive FIFO emptied
// RULE_07 - Per-source enable mask gates interrupt output
// RULE_08 - Write-one clears selected raw flags only
// RULE_09 - Raw and masked status readable, same layout
// RULE_10 - PHY interrupt sets PHY event flag
// RULE_11 - Management transaction done sets flag
// RULE_12 - Length, FCS or PHY error sets rx error
// RULE_13 - Frame exceeding FIFO space sets overflow flag
// RULE_14 - Transmit success sets transmit-done flag
// RULE_15 - Retry exhaustion or bad length sets tx error
// RULE_16 - Packet waiting in receive FIFO sets flag
// RULE_17 - Packet count: up on FCS, down on readout
// RULE_18 - Interrupt high while raw AND mask nonzero
package emc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int NUM_INT = 7;
    localparam logic [ADDR_W-1:0] OFF_TXCFG = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_RXCFG = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_TSCFG = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_RAWSTAT = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_MASKSTAT = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_INTMASK = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_PKTCNT = 4'h7;
    localparam int BIT_DUPLEX = 0;
    localparam int BIT_AUTOFCS = 1;
    localparam int BIT_PAD = 2;
    localparam int BIT_BADFCS = 0;
    localparam int BIT_MCAST = 1;
    localparam int BIT_PROMISC = 2;
    localparam int BIT_TSEN = 0;
    localparam int BIT_ENABLE = 0;
    localparam int INT_RX = 0;
    localparam int INT_TXER = 1;
    localparam int INT_TX = 2;
    localparam int INT_RXOF = 3;
    localparam int INT_RXER = 4;
    localparam int INT_MGMT = 5;
    localparam int INT_PHY = 6;
    localparam logic [2:0] TXCFG_RST = 3'h0;
    localparam logic [2:0] RXCFG_RST = 3'h0;
    localparam logic [NUM_INT-1:0] MASK_RST = 7'h00;
    typedef enum logic [1:0] {ST_OFF, ST_FLUSH, ST_RUN} emc_state_t;
endpackage

//--- hdl/emc_pkt_counter.sv
`timescale 1ns/1ps
module emc_pkt_counter #(
    parameter int CNT_W = 6
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             incr,
    input  wire logic             decr,
    output logic      [CNT_W-1:0] count
);
    import emc_pkg::*;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    wire              canDec = decr && (cnt_ff != '0);
    wire              canInc = incr && (cnt_ff != {CNT_W{1'b1}});
    // Flush wins over any simultaneous count traffic
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (clear)
            nxt_cnt = '0;
        else if (canInc && !canDec)
            nxt_cnt = cnt_ff + 1'b1; // see RULE_17
        else if (canDec && !canInc)
            nxt_cnt = cnt_ff - 1'b1; // see RULE_17
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end
    assign count = cnt_ff;

    a_count_clear: assert property (@(posedge sys_clk) disable iff (rst)
        clear |=> cnt_ff == '0) else $error("Packet count not cleared"); // see RULE_05
    a_count_inc: assert property (@(posedge sys_clk) disable iff (rst)
        (!clear && incr && !decr && cnt_ff != {CNT_W{1'b1}}) |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("Packet count did not increment"); // see RULE_17
endmodule // emc_pkt_counter

//--- hdl/emc_mac_ctrl.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module emc_mac_ctrl #(
    parameter int CNT_W = 6
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic [emc_pkg::ADDR_W-1:0]    regAddr,
    input  wire logic [emc_pkg::DATA_W-1:0]    regWdata,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    output logic      [emc_pkg::DATA_W-1:0]    regRdata,
    input  wire logic                          phyIrq,
    input  wire logic                          mgmtDone,
    input  wire logic                          rxFrameEnd,
    input  wire logic                          rxFcsBad,
    input  wire logic                          rxLenBad,
    input  wire logic                          rxPhyErr,
    input  wire logic                          rxNoSpace,
    input  wire logic                          rxPktReadDone,
    input  wire logic                          txDone,
    input  wire logic                          txRetryFail,
    input  wire logic                          txLenBad,
    output logic                               irq,
    output logic                               txEnable,
    output logic                               rxEnable,
    output logic                               rxFifoFlush,
    output logic                               rxFrameAccept,
    output logic                               rxFrameDrop,
    output logic                               fullDuplexEnable,
    output logic                               autoFcsEnable,
    output logic                               shortFramePadEnable,
    output logic                               multicastAcceptEnable,
    output logic                               promiscuousEnable,
    output logic                               timerCaptureTx,
    output logic                               timerCaptureRx
);
    import emc_pkg::*;

    // PHY interrupt is a pin from another domain; others are same-clock strobes
    logic                 phySync1_ff;
    logic                 phySync2_ff;
    logic                 phyLast_ff;
    logic [2:0]           txCfg_ff;
    logic [2:0]           rxCfg_ff;
    logic                 tsEn_ff;
    logic [NUM_INT-1:0]   raw_ff;
    logic [NUM_INT-1:0]   mask_ff;
    logic [NUM_INT-1:0]   nxt_raw;
    logic [DATA_W-1:0]    rdata_ff;
    logic                 irq_ff;
    logic                 flush_ff;
    logic                 accept_ff;
    logic                 drop_ff;
    logic                 capTx_ff;
    logic                 capRx_ff;
    emc_state_t           state_ff;
    emc_state_t           nxt_state;
    logic                 run_ff;
    logic [CNT_W-1:0]     pktCount;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    wire                  wrTx = regWr && hit(regAddr, OFF_TXCFG);
    wire                  wrRx = regWr && hit(regAddr, OFF_RXCFG);
    wire                  wrTs = regWr && hit(regAddr, OFF_TSCFG);
    wire                  wrCtrl = regWr && hit(regAddr, OFF_CTRL);
    wire                  wrClr = regWr && hit(regAddr, OFF_RAWSTAT);
    wire                  wrMask = regWr && hit(regAddr, OFF_INTMASK);
    wire                  running = (state_ff == ST_RUN);
    wire                  doEnable = wrCtrl && regWdata[BIT_ENABLE];
    wire                  doDisable = wrCtrl && !regWdata[BIT_ENABLE];
    wire                  phyRise = phySync2_ff && !phyLast_ff;

    // A bad-FCS frame is dropped only when rejection is on; length or PHY error frames always drop; errors flag either way
    wire                  rxErr = rxFrameEnd && (rxFcsBad || rxLenBad || rxPhyErr); // see RULE_12
    wire                  rxDropNow = rxFrameEnd && rxFcsBad && rxCfg_ff[BIT_BADFCS]; // see RULE_04
    wire                  rxGood = running && rxFrameEnd && !rxNoSpace && !rxDropNow
                                   && !rxLenBad && !rxPhyErr;
    wire                  pktClear = flush_ff || doEnable || doDisable;

    wire [NUM_INT-1:0]    events;
    assign events[INT_PHY] = phyRise; // see RULE_10
    assign events[INT_MGMT] = mgmtDone; // see RULE_11
    assign events[INT_RXER] = running && rxErr; // see RULE_12
    assign events[INT_RXOF] = running && rxFrameEnd && rxNoSpace; // see RULE_13
    assign events[INT_TX] = running && txDone; // see RULE_14
    assign events[INT_TXER] = running && (txRetryFail || txLenBad); // see RULE_15
    assign events[INT_RX] = pktCount != '0; // see RULE_16

    wire [NUM_INT-1:0]    masked = raw_ff & mask_ff; // see RULE_07
    wire [NUM_INT-1:0]    clrBits = wrClr ? regWdata[NUM_INT-1:0] : '0;

    wire [DATA_W-1:0]     rdMux =
        hit(regAddr, OFF_TXCFG)    ? DATA_W'(txCfg_ff) :
        hit(regAddr, OFF_RXCFG)    ? DATA_W'(rxCfg_ff) :
        hit(regAddr, OFF_TSCFG)    ? DATA_W'(tsEn_ff) :
        hit(regAddr, OFF_CTRL)     ? DATA_W'(running) :
        hit(regAddr, OFF_RAWSTAT)  ? DATA_W'(raw_ff) :
        hit(regAddr, OFF_MASKSTAT) ? DATA_W'(masked) : // see RULE_09
        hit(regAddr, OFF_INTMASK)  ? DATA_W'(mask_ff) :
        hit(regAddr, OFF_PKTCNT)   ? DATA_W'(pktCount) : '0;

    // Set beats clear so an event landing with the clear write survives
    assign nxt_raw = (raw_ff & ~clrBits) | events; // see RULE_08

    // Enable from off passes a flush cycle so no frame is taken before the FIFO reset
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF:   if (doEnable) nxt_state = ST_FLUSH;
            ST_FLUSH: nxt_state = doDisable ? ST_OFF : ST_RUN; // see RULE_06
            ST_RUN:   if (doDisable) nxt_state = ST_OFF; // see RULE_05
            default:  nxt_state = ST_OFF;
        endcase
    end

    emc_pkt_counter #(
        .CNT_W (CNT_W)
    ) u_cnt (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clear   (pktClear),
        .incr    (rxGood),
        .decr    (rxPktReadDone && running),
        .count   (pktCount)
    );

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            phySync1_ff <= 1'b0;
            phySync2_ff <= 1'b0;
            phyLast_ff <= 1'b0;
        end
        else
        begin
            phySync1_ff <= phyIrq;
            phySync2_ff <= phySync1_ff;
            phyLast_ff <= phySync2_ff;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            txCfg_ff <= TXCFG_RST;
            rxCfg_ff <= RXCFG_RST;
            tsEn_ff <= 1'b0;
            mask_ff <= MASK_RST;
        end
        else
        begin
            if (wrTx)
                txCfg_ff <= regWdata[2:0]; // see RULE_01
            if (wrRx)
                rxCfg_ff <= regWdata[2:0]; // see RULE_02
            if (wrTs)
                tsEn_ff <= regWdata[BIT_TSEN];
            if (wrMask)
                mask_ff <= regWdata[NUM_INT-1:0]; // see RULE_07
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ST_OFF;
            run_ff <= 1'b0;
            raw_ff <= '0;
            rdata_ff <= '0;
            irq_ff <= 1'b0;
            flush_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            // Enables leave straight from a flop and always agree with running
            run_ff <= (nxt_state == ST_RUN); // see RULE_05 RULE_06
            raw_ff <= nxt_raw;
            rdata_ff <= regRd ? rdMux : '0;
            // Registered from the next flags and mask, so it changes on the same edge as the raw flags
            irq_ff <= |(nxt_raw & (wrMask ? regWdata[NUM_INT-1:0] : mask_ff)); // see RULE_18
            // Any enable clears the count, so the FIFO must be reset with it
            flush_ff <= doDisable || doEnable; // see RULE_05 RULE_06
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            accept_ff <= 1'b0;
            drop_ff <= 1'b0;
            capTx_ff <= 1'b0;
            capRx_ff <= 1'b0;
        end
        else
        begin
            accept_ff <= rxGood;
            drop_ff <= running && rxFrameEnd && !rxGood; // see RULE_04
            capTx_ff <= tsEn_ff && nxt_raw[INT_TX]; // see RULE_03
            capRx_ff <= tsEn_ff && nxt_raw[INT_RX]; // see RULE_03
        end
    end

    assign regRdata = rdata_ff;
    assign irq = irq_ff;
    assign txEnable = run_ff;
    assign rxEnable = run_ff;
    assign rxFifoFlush = flush_ff;
    assign rxFrameAccept = accept_ff;
    assign rxFrameDrop = drop_ff;
    assign fullDuplexEnable = txCfg_ff[BIT_DUPLEX];
    assign autoFcsEnable = txCfg_ff[BIT_AUTOFCS];
    assign shortFramePadEnable = txCfg_ff[BIT_PAD];
    assign multicastAcceptEnable = rxCfg_ff[BIT_MCAST];
    assign promiscuousEnable = rxCfg_ff[BIT_PROMISC];
    assign timerCaptureTx = capTx_ff;
    assign timerCaptureRx = capRx_ff;

    a_irq_follows: assert property (@(posedge sys_clk) disable iff (rst)
        ##1 irq_ff == |$past(nxt_raw & (wrMask ? regWdata[NUM_INT-1:0] : mask_ff)))
        else $error("Interrupt does not track masked flags"); // see RULE_18
    a_mask_blocks: assert property (@(posedge sys_clk) disable iff (rst)
        (masked == '0 && !wrMask && events == '0) |=> !irq_ff)
        else $error("Masked source drove interrupt"); // see RULE_07
    a_clear_flag: assert property (@(posedge sys_clk) disable iff (rst)
        (wrClr && regWdata[INT_TX] && !events[INT_TX]) |=> !raw_ff[INT_TX])
        else $error("Flag not cleared"); // see RULE_08
    a_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
        (events[INT_MGMT]) |=> raw_ff[INT_MGMT])
        else $error("Event lost"); // see RULE_11
    a_tx_error: assert property (@(posedge sys_clk) disable iff (rst)
        (running && txRetryFail) |=> raw_ff[INT_TXER])
        else $error("Tx error not flagged"); // see RULE_15
    a_rx_drop: assert property (@(posedge sys_clk) disable iff (rst)
        (running && rxFrameEnd && rxFcsBad && rxCfg_ff[BIT_BADFCS]) |=> drop_ff && !accept_ff)
        else $error("Bad frame not dropped"); // see RULE_04
    a_disable_stop: assert property (@(posedge sys_clk) disable iff (rst)
        doDisable |=> !txEnable && !rxEnable && rxFifoFlush ##1 pktCount == '0)
        else $error("Disable did not stop and flush"); // see RULE_05
    a_enable_start: assert property (@(posedge sys_clk) disable iff (rst)
        (doEnable && state_ff == ST_OFF) |=> rxFifoFlush ##1 (running || $past(doDisable)))
        else $error("Enable did not start"); // see RULE_06
    a_read_masked: assert property (@(posedge sys_clk) disable iff (rst)
        (regRd && hit(regAddr, OFF_MASKSTAT)) |=> regRdata == DATA_W'($past(masked)))
        else $error("Masked status read wrong"); // see RULE_09
    a_ts_route: assert property (@(posedge sys_clk) disable iff (rst)
        !tsEn_ff |=> !timerCaptureTx && !timerCaptureRx)
        else $error("Capture routed while timestamps off"); // see RULE_03
    a_phy_flag: assert property (@(posedge sys_clk) disable iff (rst) // see RULE_10
        phyRise |=> raw_ff[INT_PHY])
        else $error("PHY event not flagged");
    a_rx_error: assert property (@(posedge sys_clk) disable iff (rst) // see RULE_12
        (running && rxErr) |=> raw_ff[INT_RXER])
        else $error("Rx error not flagged");
    a_rx_overflow: assert property (@(posedge sys_clk) disable iff (rst) // see RULE_13
        (running && rxFrameEnd && rxNoSpace) |=> raw_ff[INT_RXOF])
        else $error("Rx overflow not flagged");
    a_tx_done: assert property (@(posedge sys_clk) disable iff (rst) // see RULE_14
        (running && txDone) |=> raw_ff[INT_TX])
        else $error("Tx done not flagged");
    a_rx_pending: assert property (@(posedge sys_clk) disable iff (rst) // see RULE_16
        (pktCount != '0) |=> raw_ff[INT_RX])
        else $error("Waiting packet not flagged");
    a_tx_config: assert property (@(posedge sys_clk) disable iff (rst) // see RULE_01
        wrTx |=> txCfg_ff == $past(regWdata[2:0]))
        else $error("Tx settings not stored");
    a_rx_config: assert property (@(posedge sys_clk) disable iff (rst) // see RULE_02
        wrRx |=> rxCfg_ff == $past(regWdata[2:0]))
        else $error("Rx settings not stored");
    c_irq_rise: cover property (@(posedge sys_clk) disable iff (rst) !irq_ff ##1 irq_ff);
    c_frame_drop: cover property (@(posedge sys_clk) disable iff (rst) drop_ff);
    c_run_disable: cover property (@(posedge sys_clk) disable iff (rst) running ##1 doDisable);
    c_set_clear: cover property (@(posedge sys_clk) disable iff (rst) wrClr && events != '0);
    c_pkt_wait: cover property (@(posedge sys_clk) disable iff (rst) raw_ff[INT_RX] && running);
endmodule // emc_mac_ctrl

//--- verif/emc_phy_model.sv
`timescale 1ns/1ps
module emc_phy_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [3:0] evCode,
    input  wire logic       evGo,
    output logic            phyIrq,
    output logic            mgmtDone,
    output logic            rxFrameEnd,
    output logic            rxFcsBad,
    output logic            rxLenBad,
    output logic            rxPhyErr,
    output logic            rxNoSpace,
    output logic            rxPktReadDone,
    output logic            txDone,
    output logic            txRetryFail,
    output logic            txLenBad
);
    logic [9:0] pulse_ff;
    logic [9:0] nxt_pulse;
    // One event per command; the qualifiers only ever come with a frame end
    assign nxt_pulse = (evGo && evCode < 4'ha) ? (10'h001 << evCode) : 10'h000;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pulse_ff <= 10'h000;
            phyIrq   <= 1'b0;
        end
        else
        begin
            pulse_ff <= nxt_pulse;
            // PHY interrupt pin is a level that stays until commanded low
            if (evGo && evCode == 4'ha)
                phyIrq <= 1'b1;
            if (evGo && evCode == 4'hb)
                phyIrq <= 1'b0;
        end
    end
    assign rxFrameEnd    = |pulse_ff[4:0];
    assign rxFcsBad      = pulse_ff[1];
    assign rxLenBad      = pulse_ff[2];
    assign rxPhyErr      = pulse_ff[3];
    assign rxNoSpace     = pulse_ff[4];
    assign rxPktReadDone = pulse_ff[5];
    assign txDone        = pulse_ff[6];
    assign txRetryFail   = pulse_ff[7];
    assign txLenBad      = pulse_ff[8];
    assign mgmtDone      = pulse_ff[9];
endmodule // emc_phy_model

//--- verif/ethernet_mac_config_and_interrupts_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; $display("mismatch at %0t got %h expected %h", $time, (a), (b)); end end
module ethernet_mac_config_and_interrupts_tb;
    import emc_pkg::*;
    logic        sys_clk, rst, regWr, regRd, evGo, irq, txEnable, rxEnable, rxFifoFlush, rxFrameAccept, rxFrameDrop;
    logic        phyIrq, mgmtDone, rxFrameEnd, rxFcsBad, rxLenBad, rxPhyErr, rxNoSpace, rxPktReadDone;
    logic        txDone, txRetryFail, txLenBad, fullDuplexEnable, autoFcsEnable, shortFramePadEnable;
    logic        multicastAcceptEnable, promiscuousEnable, timerCaptureTx, timerCaptureRx;
    logic [3:0]  regAddr, evCode;
    logic [31:0] regWdata, regRdata, rdat, seed, m, cv[3];
    int          failures, num_checks, accCnt, dropCnt;
    int          pktQ[$];
    int          codes[9] = '{6, 7, 8, 9, 10, 2, 3, 1, 4};
    int          bits[9] = '{2, 1, 1, 5, 6, 4, 4, 4, 3};
    int          seq[7] = '{0, 0, 1, 5, 0, 5, 5};
    emc_mac_ctrl #(.CNT_W(6)) emc_mac_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .phyIrq(phyIrq),
        .mgmtDone(mgmtDone), .rxFrameEnd(rxFrameEnd), .rxFcsBad(rxFcsBad), .rxLenBad(rxLenBad),
        .rxPhyErr(rxPhyErr), .rxNoSpace(rxNoSpace), .rxPktReadDone(rxPktReadDone), .txDone(txDone),
        .txRetryFail(txRetryFail), .txLenBad(txLenBad), .irq(irq), .txEnable(txEnable), .rxEnable(rxEnable),
        .rxFifoFlush(rxFifoFlush), .rxFrameAccept(rxFrameAccept), .rxFrameDrop(rxFrameDrop),
        .fullDuplexEnable(fullDuplexEnable), .autoFcsEnable(autoFcsEnable),
        .shortFramePadEnable(shortFramePadEnable), .multicastAcceptEnable(multicastAcceptEnable),
        .promiscuousEnable(promiscuousEnable), .timerCaptureTx(timerCaptureTx), .timerCaptureRx(timerCaptureRx));
    emc_phy_model emc_phy_model_inst (.sys_clk(sys_clk), .rst(rst), .evCode(evCode), .evGo(evGo),
        .phyIrq(phyIrq), .mgmtDone(mgmtDone), .rxFrameEnd(rxFrameEnd), .rxFcsBad(rxFcsBad),
        .rxLenBad(rxLenBad), .rxPhyErr(rxPhyErr), .rxNoSpace(rxNoSpace), .rxPktReadDone(rxPktReadDone),
        .txDone(txDone), .txRetryFail(txRetryFail), .txLenBad(txLenBad));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Pulses are counted as they pass, so a one-cycle output is never missed
    always @(posedge sys_clk)
    begin
        if (rxFrameAccept === 1'b1) accCnt++;
        if (rxFrameDrop === 1'b1) dropCnt++;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        regAddr <= a; regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 rdat = regRdata;
    endtask
    task automatic chkreg(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        `CHK(rdat, e)
    endtask
    // Two spare edges let the PHY pin pass its two-flop synchronizer before the flags are read
    task automatic ev(input int c);
        @(posedge sys_clk);
        evCode <= 4'(c); evGo <= 1'b1;
        @(posedge sys_clk);
        evGo <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #400000;
        failures++;
        summarize();
    end
    initial
    begin
        rst = 1'b1; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWdata = 32'h0; evGo = 1'b0; evCode = 4'h0;
        seed = 32'h8119; failures = 0; num_checks = 0; accCnt = 0; dropCnt = 0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a < 9; a++) chkreg(4'(a), 32'h0);
        wr(4'h8, 32'hffffffff);
        chkreg(4'h8, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            cv[i] = xs() & 32'h7;
            wr(4'(i), cv[i]);
            chkreg(4'(i), (i == 2) ? (cv[i] & 32'h1) : cv[i]);
        end
        `CHK({shortFramePadEnable, autoFcsEnable, fullDuplexEnable}, cv[0][2:0])
        `CHK({promiscuousEnable, multicastAcceptEnable}, cv[1][2:1])
        $display("test config done");
        wr(OFF_CTRL, 32'h1);
        #1 `CHK(rxFifoFlush, 1'b1)
        @(posedge sys_clk);
        #1 `CHK({txEnable, rxEnable}, 2'b11)
        wr(OFF_INTMASK, 32'h7f);
        wr(OFF_RXCFG, 32'h0);
        for (int k = 0; k < 9; k++)
        begin
            ev(codes[k]);
            rd(OFF_RAWSTAT);
            `CHK(rdat[bits[k]], 1'b1)
            `CHK(irq, 1'b1)
            wr(OFF_RAWSTAT, 32'h1 << bits[k]);
            rd(OFF_RAWSTAT);
            `CHK(rdat[bits[k]], 1'b0)
        end
        ev(11);
        $display("test events done");
        wr(OFF_CTRL, 32'h0);
        #1 `CHK(rxFifoFlush, 1'b1)
        @(posedge sys_clk);
        #1 `CHK({txEnable, rxEnable}, 2'b00)
        wr(OFF_RAWSTAT, 32'h7f);
        ev(6);
        rd(OFF_RAWSTAT);
        `CHK(rdat[INT_TX], 1'b0)
        $display("test disable done");
        wr(OFF_RXCFG, 32'h1 << BIT_BADFCS);
        wr(OFF_CTRL, 32'h1);
        accCnt = 0; dropCnt = 0; pktQ.delete();
        chkreg(OFF_PKTCNT, 32'h0);
        for (int k = 0; k < 7; k++)
        begin
            ev(seq[k]);
            if (seq[k] == 0) pktQ.push_back(k);
            if (seq[k] == 5 && pktQ.size() > 0) void'(pktQ.pop_front());
            chkreg(OFF_PKTCNT, 32'(pktQ.size()));
            wr(OFF_RAWSTAT, 32'h1);
            rd(OFF_RAWSTAT);
            `CHK(rdat[INT_RX], (pktQ.size() > 0))
        end
        `CHK(accCnt, 3)
        `CHK(dropCnt, 1)
        wr(OFF_RXCFG, 32'h0);
        ev(1);
        pktQ.push_back(1);
        chkreg(OFF_PKTCNT, 32'(pktQ.size()));
        wr(OFF_CTRL, 32'h1);
        pktQ.delete();
        #1 `CHK(rxFifoFlush, 1'b1)
        chkreg(OFF_PKTCNT, 32'(pktQ.size()));
        ev(5);
        $display("test count done");
        wr(OFF_RAWSTAT, 32'h7f);
        ev(6); ev(9); ev(10);
        chkreg(OFF_RAWSTAT, 32'h64);
        for (int k = 0; k < 6; k++)
        begin
            m = (k == 0) ? 32'h0 : (k == 1) ? 32'h7f : xs() & 32'h7f;
            wr(OFF_INTMASK, m);
            chkreg(OFF_INTMASK, m);
            chkreg(OFF_MASKSTAT, m & 32'h64);
            `CHK(irq, |(m & 32'h64))
        end
        wr(OFF_TSCFG, 32'h1);
        repeat (2) @(posedge sys_clk);
        #1 `CHK({timerCaptureTx, timerCaptureRx}, 2'b10)
        ev(0);
        #1 `CHK(timerCaptureRx, 1'b1)
        wr(OFF_TSCFG, 32'h0);
        repeat (2) @(posedge sys_clk);
        #1 `CHK({timerCaptureTx, timerCaptureRx}, 2'b00)
        $display("test mask done");
        summarize();
    end
endmodule // ethernet_mac_config_and_interrupts_tb
